// ### hw/bridge_status_regs.sv
// Summary of operation
// RULE_01: Detected parity flag bit 15 sets on any parity error, enable ignored.
// RULE_02: Error flags clear only by writing one; hardware sets them.
// RULE_03: System error flag bit 14 sets when enabled and system error driven.
// RULE_04: Master abort flag bit 13 sets on master abort of own cycles.
// RULE_05: Received target abort flag bit 12 sets when target aborts own cycles.
// RULE_06: Signaled target abort bit 11 sets when device target-aborts claimed cycle.
// RULE_07: Select timing field reads fixed medium encoding 01.
// RULE_08: Bit 8 sets when initiator, response enabled, parity error asserted or observed.
// RULE_09: Bit 7 reads one: back-to-back capable as target.
// RULE_10: Bits 6 and 5 read zero.
// RULE_11: Status register reads 0280h after reset.
// RULE_12: Revision byte is read-only, fixed by parameter.
// RULE_13: Programming interface byte at 09h reads 00h.
// RULE_14: Sub-class byte at 0Ah reads 01h.
// RULE_15: Base class byte at 0Bh reads 06h.
// RULE_16: Parity response enable gates normal parity error action.
// RULE_17: System error enable gates system error generation.
// RULE_18: Zero writes and read-only writes change nothing; reserved bits read zero.
`timescale 1ns/1ps
`default_nettype none
`include "bridge_status_defines.svh"

module bridge_status_regs
   import bridge_status_pkg::*;
#(
   parameter logic [7:0] REVISION = `REVISION_DEFAULT
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire cfg_access_t cfg,
   input wire logic [15:0] command_reg,
   input wire error_events_t events,
   output logic [31:0] cfg_rdata,
   output logic cfg_ack,
   output logic serr_out
);

   // ==========================================================
   // Enables and event qualification
   // ==========================================================
   logic parity_response_enable;
   logic system_error_enable;
   logic [4:0] set_vec;
   logic [4:0] clear_vec;
   logic [4:0] flag_vec;
   logic [15:0] bus_status_reg;
   logic status_word_hit;
   logic [15:0] wr_high;

   assign parity_response_enable = command_reg[`CMD_PARITY_RESPONSE]; // RULE_16
   assign system_error_enable = command_reg[`CMD_SYSTEM_ERROR]; // RULE_17

   // Index order: 0 initiator parity, 1 sig tabort, 2 rx tabort, 3 mabort, 4 serr
   // Parity flag kept separate below, as it ignores any enable
   logic detected_parity_flag;
   logic system_error_signaled;
   logic master_abort_flag;
   logic received_target_abort_flag;
   logic signaled_target_abort;
   logic initiator_parity_flag;

   assign set_vec[0] = events.initiator && parity_response_enable &&
      ((events.read_cycle && events.perr_driven) ||
       (!events.read_cycle && events.perr_observed)); // RULE_08
   assign set_vec[1] = events.target_abort_tx; // RULE_06
   assign set_vec[2] = events.target_abort_rx; // RULE_05
   assign set_vec[3] = events.master_abort; // RULE_04
   assign set_vec[4] = events.serr_driven && system_error_enable; // RULE_03

   // ==========================================================
   // Write-one-to-clear decode
   // ==========================================================
   function automatic logic [15:0] status_write(input cfg_access_t a);
      logic [15:0] w;
      w = 16'h0000;
      if (a.wr && a.addr[7:2] == 6'(`OFF_BUS_STATUS >> 2)) begin
         if (a.byte_en[2]) begin
            w[7:0] = a.wdata[23:16];
         end
         if (a.byte_en[3]) begin
            w[15:8] = a.wdata[31:24];
         end
      end
      return w;
   endfunction

   assign wr_high = status_write(cfg); // RULE_18
   assign clear_vec[0] = wr_high[`BIT_INITIATOR_PARITY]; // RULE_02
   assign clear_vec[1] = wr_high[`BIT_SIGNALED_TABORT];
   assign clear_vec[2] = wr_high[`BIT_RECEIVED_TABORT];
   assign clear_vec[3] = wr_high[`BIT_MASTER_ABORT];
   assign clear_vec[4] = wr_high[`BIT_SYSTEM_ERROR];

   // ==========================================================
   // Sticky flags
   // ==========================================================
   genvar i;
   generate
      for (i = 0; i < 5; i++) begin : g_flag
         status_flag u_flag (
            .clk(clk),
            .rst_b(rst_b),
            .set(set_vec[i]),
            .clear(clear_vec[i]),
            .flag(flag_vec[i])
         ); // RULE_02
      end
   endgenerate

   status_flag u_parity (
      .clk(clk),
      .rst_b(rst_b),
      .set(events.parity_seen),
      .clear(wr_high[`BIT_DETECTED_PARITY]),
      .flag(detected_parity_flag)
   ); // RULE_01

   assign initiator_parity_flag = flag_vec[0];
   assign signaled_target_abort = flag_vec[1];
   assign received_target_abort_flag = flag_vec[2];
   assign master_abort_flag = flag_vec[3];
   assign system_error_signaled = flag_vec[4];

   // ==========================================================
   // Status word assembly
   // ==========================================================
   always_comb begin
      bus_status_reg = `STATUS_RESET; // RULE_11
      bus_status_reg[`BIT_DETECTED_PARITY] = detected_parity_flag;
      bus_status_reg[`BIT_SYSTEM_ERROR] = system_error_signaled;
      bus_status_reg[`BIT_MASTER_ABORT] = master_abort_flag;
      bus_status_reg[`BIT_RECEIVED_TABORT] = received_target_abort_flag;
      bus_status_reg[`BIT_SIGNALED_TABORT] = signaled_target_abort;
      bus_status_reg[10:9] = `SELECT_TIMING_MEDIUM; // RULE_07
      bus_status_reg[`BIT_INITIATOR_PARITY] = initiator_parity_flag;
      bus_status_reg[`BIT_BACK_TO_BACK] = 1'b1; // RULE_09
      bus_status_reg[`BIT_USER_FEATURE] = 1'b0; // RULE_10
      bus_status_reg[`BIT_DOUBLE_SPEED] = 1'b0; // RULE_10
      bus_status_reg[4:0] = 5'h00; // RULE_18
   end

   // ==========================================================
   // Read path
   // ==========================================================
   assign status_word_hit = cfg.addr[7:2] == 6'(`OFF_BUS_STATUS >> 2);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cfg_rdata <= 32'h00000000;
      end else if (cfg.rd) begin
         if (status_word_hit) begin
            cfg_rdata <= {bus_status_reg, 16'h0000};
         end else if (cfg.addr[7:2] == 6'(`OFF_REVISION >> 2)) begin
            cfg_rdata <= {`CLASS_VALUE, `SUBCLASS_VALUE, `PROG_IF_VALUE,
               REVISION}; // RULE_12 RULE_13 RULE_14 RULE_15
         end else begin
            cfg_rdata <= 32'h00000000;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cfg_ack <= 1'b0;
      end else begin
         cfg_ack <= cfg.rd || cfg.wr;
      end
   end

   // System error output only when enabled
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         serr_out <= 1'b0;
      end else begin
         serr_out <= events.serr_driven && system_error_enable; // RULE_17
      end
   end

endmodule // bridge_status_regs

`default_nettype wire

// ### hw/bridge_status_defines.svh
`ifndef BRIDGE_STATUS_DEFINES_SVH
`define BRIDGE_STATUS_DEFINES_SVH

// Configuration offsets (byte addresses)
`define OFF_BUS_STATUS 8'h06
`define OFF_REVISION 8'h08
`define OFF_PROG_IF 8'h09
`define OFF_SUBCLASS 8'h0A
`define OFF_CLASS 8'h0B

// Status bit positions
`define BIT_DETECTED_PARITY 15
`define BIT_SYSTEM_ERROR 14
`define BIT_MASTER_ABORT 13
`define BIT_RECEIVED_TABORT 12
`define BIT_SIGNALED_TABORT 11
`define BIT_INITIATOR_PARITY 8
`define BIT_BACK_TO_BACK 7
`define BIT_USER_FEATURE 6
`define BIT_DOUBLE_SPEED 5

// Fixed values
`define STATUS_RESET 16'h0280
`define SELECT_TIMING_MEDIUM 2'h1
`define PROG_IF_VALUE 8'h00
`define SUBCLASS_VALUE 8'h01
`define CLASS_VALUE 8'h06
`define REVISION_DEFAULT 8'h00

// Command register bit positions
`define CMD_PARITY_RESPONSE 6
`define CMD_SYSTEM_ERROR 8

`endif

// ### hw/bridge_status_pkg.sv
package bridge_status_pkg;

   // Error events, one-cycle pulses from the bus engine
   typedef struct packed {
      logic parity_seen;
      logic serr_driven;
      logic master_abort;
      logic target_abort_rx;
      logic target_abort_tx;
      logic initiator;
      logic read_cycle;
      logic perr_driven;
      logic perr_observed;
   } error_events_t;

   // Configuration access from the host bridge
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [3:0] byte_en;
      logic [31:0] wdata;
   } cfg_access_t;

endpackage

// ### hw/status_flag.sv
`timescale 1ns/1ps
`default_nettype none

module status_flag (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic set,
   input wire logic clear,
   output logic flag
);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         flag <= 1'b0;
      end else if (set) begin
         flag <= 1'b1;
      end else if (clear) begin
         flag <= 1'b0;
      end
   end

endmodule // status_flag

`default_nettype wire

// ### bench/bridge_status_props.sv
`timescale 1ns/1ps
`default_nettype none
module bridge_status_props
   import bridge_status_pkg::*;
#(
   parameter logic [7:0] REVISION = 8'h00
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire cfg_access_t cfg,
   input wire logic [15:0] command_reg,
   input wire error_events_t events,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_ack,
   input wire logic serr_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic rd_st;
   logic perr_hit;
   assign rd_st = cfg.rd && cfg.addr[7:2] == 6'h01;
   assign perr_hit = events.read_cycle ? events.perr_driven : events.perr_observed;
   // ==========
   // Flag setting
   a_parity_any: assert property (events.parity_seen ##1 !cfg.wr ##1 rd_st |=> cfg_rdata[31])
      else $error("parity flag not set");
   a_serr_flag: assert property (events.serr_driven && command_reg[8] ##1 !cfg.wr ##1 rd_st
      |=> cfg_rdata[30])
      else $error("system error flag not set");
   a_master_abort: assert property (events.master_abort ##1 !cfg.wr ##1 rd_st |=> cfg_rdata[29])
      else $error("master abort flag not set");
   a_target_rx: assert property (events.target_abort_rx ##1 !cfg.wr ##1 rd_st |=> cfg_rdata[28])
      else $error("received abort flag not set");
   a_target_tx: assert property (events.target_abort_tx ##1 !cfg.wr ##1 rd_st |=> cfg_rdata[27])
      else $error("signaled abort flag not set");
   a_init_parity: assert property (events.initiator && command_reg[6]
      && perr_hit ##1 !cfg.wr ##1 rd_st |=> cfg_rdata[24])
      else $error("initiator parity flag not set");
   // ==========
   // Fixed fields and gating
   a_status_fixed: assert property (rd_st |=> {cfg_rdata[26:25], cfg_rdata[23:16]} == 10'h180)
      else $error("fixed status bits wrong");
   a_class_bytes: assert property (cfg.rd && cfg.addr[7:2] == 6'h02
      |=> cfg_rdata == {8'h06, 8'h01, 8'h00, REVISION})
      else $error("class dword wrong");
   a_serr_gate: assert property (serr_out == $past(events.serr_driven && command_reg[8]))
      else $error("system error output wrong");
   a_ack_follows: assert property (cfg_ack == $past(cfg.rd || cfg.wr))
      else $error("access acknowledge wrong");
endmodule // bridge_status_props
bind bridge_status_regs bridge_status_props #(.REVISION(REVISION)) bridge_status_props_inst (
   .clk(clk), .rst_b(rst_b), .cfg(cfg), .command_reg(command_reg), .events(events),
   .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .serr_out(serr_out));
`default_nettype wire

// ### bench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
   import bridge_status_pkg::*;
(
   input wire logic clk,
   input wire logic cfg_ack,
   input wire logic [31:0] cfg_rdata,
   output var cfg_access_t cfg
);
   initial cfg = '0;
   // ==========
   // One configuration cycle; idle address, byte-enable and data lines show inverted values, rd and wr go low
   task automatic access(input logic w, input logic [7:0] a, input logic [3:0] be,
         input logic [31:0] wd, output logic [31:0] rv);
      @(posedge clk);
      #1;
      cfg = '{rd: !w, wr: w, addr: a, byte_en: be, wdata: wd};
      @(posedge clk);
      #1;
      rv = cfg_ack ? cfg_rdata : 'x;
      cfg = '{rd: 1'b0, wr: 1'b0, addr: ~a, byte_en: ~be, wdata: ~wd};
   endtask
endmodule // host_model
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import bridge_status_pkg::*;
   logic clk = 1'b0;
   logic rst_b;
   logic [15:0] command_reg;
   error_events_t events;
   cfg_access_t cfg;
   logic [31:0] cfg_rdata;
   logic [31:0] d;
   logic cfg_ack;
   logic serr_out;
   logic serr_seen;
   int fails = 0;
   int num_checks = 0;
   logic [8:0] ev [7] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h10E, 9'h109};
   logic [15:0] fl [7] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h8100, 16'h8100};
   always #4 clk = ~clk;
   bridge_status_regs #(.REVISION(8'h5A)) bridge_status_regs_inst (.clk(clk), .rst_b(rst_b),
      .cfg(cfg), .command_reg(command_reg), .events(events), .cfg_rdata(cfg_rdata),
      .cfg_ack(cfg_ack), .serr_out(serr_out));
   host_model host_model_inst (.clk(clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg(cfg));
   // ==========
   // Helpers
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task complete_run;
      $display("checks=%0d mismatches=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task rd(input logic [7:0] a);
      host_model_inst.access(1'b0, a, 4'hF, 32'h0, d);
   endtask
   task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
      host_model_inst.access(1'b1, a, be, wd, d);
   endtask
   task pulse(input logic [8:0] e);
      @(posedge clk);
      #1;
      events = e;
      @(posedge clk);
      #1;
      events = '0;
      serr_seen = serr_out;
   endtask
   // ==========
   // Tests
   initial begin
      #5000;
      fails++;
      complete_run;
   end
   initial begin
      rst_b = 1'b0;
      command_reg = 16'h0;
      events = '0;
      repeat (6) @(posedge clk);
      #1;
      rst_b = 1'b1;
      rd(8'h04); check(d, 32'h0280_0000);
      rd(8'h08); check(d, 32'h0601_005A);
      wr(8'h08, 4'hF, 32'hFFFF_FFFF); rd(8'h08); check(d, 32'h0601_005A);
      wr(8'h04, 4'hC, 32'hFFFF_0000); rd(8'h04); check(d, 32'h0280_0000);
      rd(8'h40); check(d, 32'h0);
      command_reg = 16'h0140;
      for (int i = 0; i < 7; i++) begin
         pulse(ev[i]);
         check({31'h0, serr_seen}, {31'h0, i == 1});
         rd(8'h04); check(d, {16'h0280 | fl[i], 16'h0});
         wr(8'h04, 4'hC, 32'h0); rd(8'h04); check(d, {16'h0280 | fl[i], 16'h0});
         wr(8'h04, 4'hC, {fl[i], 16'h0}); rd(8'h04); check(d, 32'h0280_0000);
      end
      command_reg = 16'h0;
      pulse(9'h18E);
      check({31'h0, serr_seen}, 32'h0);
      rd(8'h04); check(d, 32'h8280_0000);
      complete_run;
   end
endmodule // tb
`default_nettype wire
